// File: logic/async_tx_defs.vh
/*
 * Constants for the asynchronous transmit packet formatter: register
 * offsets, register field positions, control quadlet fields and codes.
 * Assumes it is included by bare name from each design file.
 */
`ifndef ASYNC_TX_DEFS_VH
`define ASYNC_TX_DEFS_VH

// ************************************************
// Register byte offsets on the APB bus
// ************************************************
`define ADDR_TXDATA      8'h00
`define ADDR_CTRL        8'h04
`define ADDR_STATUS      8'h08
`define ADDR_RXSTAT      8'h0c

// ************************************************
// Control register fields
// ************************************************
`define CTRL_GO_BIT      0
`define CTRL_FLUSH_BIT   1
`define CTRL_LEN_LSB     8
`define CTRL_LEN_MSB     12

// ************************************************
// Status register fields
// ************************************************
`define ST_BUSY_BIT      0
`define ST_SPDERR_BIT    1
`define ST_LVL_LSB       8
`define ST_LVL_MSB       12
`define ST_CLS_LSB       16
`define ST_CLS_MSB       17

// ************************************************
// Control quadlet fields of a queued packet
// ************************************************
`define Q0_IMM_BIT       23
`define Q0_SPD_MSB       17
`define Q0_SPD_LSB       16
`define Q0_RT_MSB        9
`define Q0_RT_LSB        8
`define Q0_TCODE_MSB     7
`define Q0_TCODE_LSB     4
`define Q0_PRI_MSB       3
`define Q0_PRI_LSB       0

// ************************************************
// Codes
// ************************************************
`define SPD_RESERVED     2'h3
`define TCODE_UNFMT      4'he
`define TC_WR_QUAD_REQ   4'h0
`define TC_WR_BLK_REQ    4'h1
`define TC_WR_RESP       4'h2
`define TC_RD_QUAD_REQ   4'h4
`define TC_RD_BLK_REQ    4'h5
`define TC_RD_QUAD_RESP  4'h6
`define TC_RD_BLK_RESP   4'h7
`define TC_LOCK_REQ      4'h9
`define TC_LOCK_RESP     4'hb
`define CLS_NODATA       2'h0
`define CLS_QUADLET      2'h1
`define CLS_BLOCK        2'h2
`define CLS_NONE         2'h3

// ************************************************
// Receive status quadlet layout
// ************************************************
`define RXST_SPD_MSB     17
`define RXST_SPD_LSB     16
`define RXST_ACK_MSB     3
`define RXST_ACK_LSB     0

`endif

// File: logic/async_tx_formatter.v
/*
 * Asynchronous transmit packet formatter. Software loads packet
 * quadlets over APB into a transmit FIFO, then starts the packet; the
 * block arbitrates (or follows an acknowledge at once) and streams
 * quadlets to the link core through a two-entry buffer.
 * Assumes link core and arbiter signals share clk_i (40 MHz).
 */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "async_tx_defs.vh"

// Notes on behaviour
// - Immediate flag: send after acknowledge, no arbitration
// - Speed code drives link speed; 11 reserved
// - Retry code passed to link unchanged
// - Non-zero priority selects priority arbitration
// - First payload byte in top byte
// - Unformatted quadlets sent raw, no CRC
// - Receive packets sorted into three formats
// - Receive status quadlet holds speed, acknowledge
module async_tx_formatter #(
	parameter DEPTH = 24,             // Transmit FIFO quadlets
	parameter AW    = 5               // FIFO pointer width
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        srst_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// Arbitration with the link core
	output reg         arb_req_o,
	output reg         arb_prio_o,
	input  wire        arb_grant_i,
	input  wire        ack_sent_i,
	// Transmit stream to the link core
	output wire [31:0] tx_data_o,
	output wire        tx_valid_o,
	output wire        tx_first_o,
	output wire        tx_last_o,
	input  wire        tx_ready_i,
	// Per-packet attributes, stable for the packet
	output reg  [1:0]  tx_spd_o,
	output reg  [1:0]  tx_rt_o,
	output reg         tx_crc_en_o,
	output reg         tx_no_arb_o,
	// Receive header from the link core
	input  wire        rx_hdr_valid_i,
	input  wire [3:0]  rx_tcode_i,
	input  wire [1:0]  rx_spd_i,
	input  wire [3:0]  rx_ack_i,
	output wire [1:0]  rx_class_o,
	output wire [31:0] rx_status_o,
	output wire        rx_done_o
);

	// ************************************************
	// State encoding
	// ************************************************
	localparam [4:0] S_IDLE  = 5'h01;  // Waiting for a start
	localparam [4:0] S_ACK   = 5'h02;  // Waiting for acknowledge
	localparam [4:0] S_ARB   = 5'h04;  // Requesting the bus
	localparam [4:0] S_SEND  = 5'h08;  // Streaming quadlets
	localparam [4:0] S_DRAIN = 5'h10;  // Buffer emptying

	// ************************************************
	// Declarations
	// ************************************************
	reg  [31:0]   mem [0:DEPTH-1];    // Transmit FIFO storage
	reg  [AW-1:0] wr_ptr_r;           // Write pointer
	reg  [AW-1:0] rd_ptr_r;           // Read pointer
	reg  [AW:0]   lvl_r;              // Quadlets held
	reg  [4:0]    state_r;            // One-hot state
	reg  [4:0]    state_nxt;          // Next state
	reg           go_r;               // Start pending
	reg  [4:0]    len_r;              // Packet length in quadlets
	reg  [4:0]    sent_r;             // Quadlets popped so far
	reg           spd_err_r;          // Reserved speed seen, sticky
	wire          setup;              // APB setup phase
	wire          wr_acc;             // APB write, access phase
	wire          push_q;             // Quadlet into FIFO
	wire          pop_q;              // Quadlet out to buffer
	wire          buf_in_ready;       // Buffer can take a word
	wire          buf_out_valid;      // Buffer holds a word
	wire [33:0]   buf_out;            // {first, last, data}
	wire [31:0]   head_q;             // Quadlet at FIFO head
	wire          start_ok;           // Whole packet present
	wire          head_bad_spd;       // Head speed is reserved
	wire          mapped;             // Address decodes

	assign head_q       = mem[rd_ptr_r];
	assign setup        = psel_i & ~penable_i;
	assign wr_acc       = psel_i & penable_i & pwrite_i;
	assign mapped       = (paddr_i == `ADDR_TXDATA) | (paddr_i == `ADDR_CTRL) |
	                      (paddr_i == `ADDR_STATUS) | (paddr_i == `ADDR_RXSTAT);
	// Full FIFO drops the write; the bus sees an error
	assign push_q       = wr_acc & (paddr_i == `ADDR_TXDATA) & (lvl_r != DEPTH);
	// Start only once the host has loaded every quadlet
	assign start_ok     = go_r & (len_r != 5'h00) & (lvl_r >= {1'b0, len_r});
	assign head_bad_spd = (head_q[`Q0_SPD_MSB:`Q0_SPD_LSB] == `SPD_RESERVED);
	// Quadlets flow only while sending and buffer has room
	assign pop_q        = state_r[3] & buf_in_ready & (sent_r != len_r);

	// ************************************************
	// APB slave: zero wait states, answer in access phase
	// ************************************************
	always @(posedge clk_i) begin
		if (srst_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & (~mapped |
				(pwrite_i & (paddr_i == `ADDR_TXDATA) & (lvl_r == DEPTH)) |
				(pwrite_i & (paddr_i == `ADDR_CTRL) & ~state_r[0]));
			prdata_o  <= 32'h0000_0000;
			if (setup & ~pwrite_i) begin
				case (paddr_i)
				`ADDR_CTRL: begin
					prdata_o[`CTRL_GO_BIT] <= go_r;
					prdata_o[`CTRL_LEN_MSB:`CTRL_LEN_LSB] <= len_r;
				end
				`ADDR_STATUS: begin
					prdata_o[`ST_BUSY_BIT]   <= ~state_r[0];
					prdata_o[`ST_SPDERR_BIT] <= spd_err_r;
					prdata_o[`ST_LVL_MSB:`ST_LVL_LSB] <= lvl_r[4:0];
					prdata_o[`ST_CLS_MSB:`ST_CLS_LSB] <= rx_class_o;
				end
				`ADDR_RXSTAT: begin
					prdata_o <= rx_status_o;
				end
				default: begin
					prdata_o <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

	// ************************************************
	// Control register: start, length, flush
	// ************************************************
	always @(posedge clk_i) begin
		if (srst_i) begin
			go_r  <= 1'b0;
			len_r <= 5'h00;
		end else if (state_r[0] & start_ok) begin
			// Start is consumed as the packet is taken
			go_r <= 1'b0;
		end else if (wr_acc & (paddr_i == `ADDR_CTRL) & state_r[0]) begin
			// Length and start only change while idle
			go_r  <= pwdata_i[`CTRL_GO_BIT];
			len_r <= pwdata_i[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
		end
	end

	// ************************************************
	// Sticky reserved-speed flag; set wins over clear
	// ************************************************
	always @(posedge clk_i) begin
		if (srst_i)
			spd_err_r <= 1'b0;
		else if (state_r[0] & start_ok & head_bad_spd)
			spd_err_r <= 1'b1;
		else if (wr_acc & (paddr_i == `ADDR_STATUS) & pwdata_i[`ST_SPDERR_BIT])
			spd_err_r <= 1'b0;
	end

	// ************************************************
	// Transmit FIFO: quadlets kept in load order
	// ************************************************
	// Words are stored untouched, so the first payload byte stays in
	// bits 31:24 of the first data quadlet; no swapping is done.
	always @(posedge clk_i) begin
		if (push_q)
			mem[wr_ptr_r] <= pwdata_i;
	end

	// Pointers and level; flush only honoured while idle
	always @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			lvl_r    <= {(AW+1){1'b0}};
		end else if (wr_acc & (paddr_i == `ADDR_CTRL) & state_r[0] &
		             pwdata_i[`CTRL_FLUSH_BIT]) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			lvl_r    <= {(AW+1){1'b0}};
		end else begin
			// Non-power-of-two depth: wrap by compare
			if (push_q)
				wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			if (pop_q)
				rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			if (push_q & ~pop_q)
				lvl_r <= lvl_r + 1'b1;
			else if (pop_q & ~push_q)
				lvl_r <= lvl_r - 1'b1;
		end
	end

	// ************************************************
	// Packet sequencer
	// ************************************************
	always @* begin
		state_nxt = state_r;
		case (state_r)
		S_IDLE: begin
			if (start_ok & head_bad_spd)
				state_nxt = S_SEND; // Still drained, but link never sees it
			else if (start_ok & head_q[`Q0_IMM_BIT])
				state_nxt = S_ACK;
			else if (start_ok)
				state_nxt = S_ARB;
		end
		S_ACK: begin
			// Follows the acknowledge at once, skipping arbitration
			if (ack_sent_i)
				state_nxt = S_SEND;
		end
		S_ARB: begin
			if (arb_grant_i)
				state_nxt = S_SEND;
		end
		S_SEND: begin
			if (sent_r == len_r)
				state_nxt = S_DRAIN;
		end
		S_DRAIN: begin
			// Attributes must hold until the last word has left
			if (~buf_out_valid)
				state_nxt = S_IDLE;
		end
		default: begin
			state_nxt = S_IDLE;
		end
		endcase
	end

	// State register and per-packet attributes
	always @(posedge clk_i) begin
		if (srst_i) begin
			state_r     <= S_IDLE;
			sent_r      <= 5'h00;
			arb_req_o   <= 1'b0;
			arb_prio_o  <= 1'b0;
			tx_spd_o    <= 2'h0;
			tx_rt_o     <= 2'h0;
			tx_crc_en_o <= 1'b1;
			tx_no_arb_o <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			arb_req_o <= (state_nxt == S_ARB);
			if (state_r[0] & start_ok) begin
				sent_r      <= 5'h00;
				tx_spd_o    <= head_q[`Q0_SPD_MSB:`Q0_SPD_LSB];
				tx_rt_o     <= head_q[`Q0_RT_MSB:`Q0_RT_LSB];
				arb_prio_o  <= (head_q[`Q0_PRI_MSB:`Q0_PRI_LSB] != 4'h0);
				tx_no_arb_o <= head_q[`Q0_IMM_BIT];
				// Raw packets carry no header or data CRC
				tx_crc_en_o <= (head_q[`Q0_TCODE_MSB:`Q0_TCODE_LSB] != `TCODE_UNFMT);
			end else if (pop_q) begin
				sent_r <= sent_r + 5'h01;
			end
		end
	end

	// ************************************************
	// Output buffer: a link stall loses no quadlet
	// ************************************************
	// A packet with a reserved speed is popped but never offered.
	wire        buf_in_valid;         // Word offered to buffer
	wire [33:0] buf_in;               // {first, last, data}
	reg         drop_r;               // Current packet is discarded

	always @(posedge clk_i) begin
		if (srst_i)
			drop_r <= 1'b0;
		else if (state_r[0] & start_ok)
			drop_r <= head_bad_spd;
	end

	assign buf_in_valid = pop_q & ~drop_r;
	// Zero-length block packets simply have no payload quadlets
	assign buf_in       = {(sent_r == 5'h00), (sent_r == len_r - 5'h01), head_q};

	two_entry_buffer #(
		.W (34)
	) u_out_buf (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (buf_in),
		.out_valid_o (buf_out_valid),
		.out_ready_i (tx_ready_i),
		.out_data_o  (buf_out)
	);

	assign tx_valid_o = buf_out_valid;
	assign tx_first_o = buf_out[33];
	assign tx_last_o  = buf_out[32];
	assign tx_data_o  = buf_out[31:0];

	// ************************************************
	// Receive sorting and status quadlet
	// ************************************************
	rx_format_sorter u_rx_sort (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.hdr_valid_i (rx_hdr_valid_i),
		.tcode_i     (rx_tcode_i),
		.spd_i       (rx_spd_i),
		.ack_i       (rx_ack_i),
		.class_o     (rx_class_o),
		.status_o    (rx_status_o),
		.done_o      (rx_done_o)
	);

endmodule // async_tx_formatter

// File: logic/rx_format_sorter.v
/*
 * Sorts a received packet into its storage format and builds the
 * trailing status quadlet. Assumes header inputs come from the link
 * core on the same clock.
 */
`timescale 1ns/10ps
`include "async_tx_defs.vh"

module rx_format_sorter (
	// Clock and reset
	input  wire        clk_i,
	input  wire        srst_i,
	// Received header
	input  wire        hdr_valid_i,
	input  wire [3:0]  tcode_i,
	input  wire [1:0]  spd_i,
	input  wire [3:0]  ack_i,
	// Results
	output reg  [1:0]  class_o,
	output reg  [31:0] status_o,
	output reg         done_o
);

	reg [1:0] cls;                    // Combinational class

	// Storage format from transaction code
	always @* begin
		case (tcode_i)
		`TC_RD_QUAD_REQ,
		`TC_WR_RESP:      cls = `CLS_NODATA;
		`TC_WR_QUAD_REQ,
		`TC_RD_QUAD_RESP,
		`TC_RD_BLK_REQ:   cls = `CLS_QUADLET;
		`TC_LOCK_REQ,
		`TC_LOCK_RESP,
		`TC_WR_BLK_REQ,
		`TC_RD_BLK_RESP:  cls = `CLS_BLOCK;
		default:          cls = `CLS_NONE;
		endcase
	end

	// Latch class and status quadlet per header
	always @(posedge clk_i) begin
		if (srst_i) begin
			class_o  <= `CLS_NONE;
			status_o <= 32'h0000_0000;
			done_o   <= 1'b0;
		end else begin
			done_o <= hdr_valid_i;
			if (hdr_valid_i) begin
				class_o  <= cls;
				status_o <= 32'h0000_0000;
				status_o[`RXST_SPD_MSB:`RXST_SPD_LSB] <= spd_i;
				status_o[`RXST_ACK_MSB:`RXST_ACK_LSB] <= ack_i;
			end
		end
	end

endmodule // rx_format_sorter

// File: logic/two_entry_buffer.v
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "async_tx_defs.vh"

module two_entry_buffer #(
	parameter W = 34                 // Word width
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         srst_i,
	// Filling side
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	// Draining side
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);

	reg [W-1:0] slot0_r;              // Head entry
	reg [W-1:0] slot1_r;              // Second entry
	reg [1:0]   cnt_r;                // Entries held
	reg         vld_r;                // Head valid, kept in its own flop
	wire        push;                 // Word accepted
	wire        pop;                  // Word taken

	assign push        = in_valid_i & (cnt_r != 2'h2);
	assign pop         = out_ready_i & (cnt_r != 2'h0);
	assign in_ready_o  = (cnt_r != 2'h2);
	// Registered so the block's valid output leaves straight from a flop
	assign out_valid_o = vld_r;
	assign out_data_o  = slot0_r;

	// Shift register of two; head always in slot0
	always @(posedge clk_i) begin
		if (srst_i) begin
			cnt_r   <= 2'h0;
			vld_r   <= 1'b0;
			slot0_r <= {W{1'b0}};
			slot1_r <= {W{1'b0}};
		end else begin
			case ({push, pop})
			2'b10: begin
				if (cnt_r == 2'h0)
					slot0_r <= in_data_i;
				else
					slot1_r <= in_data_i;
				cnt_r <= cnt_r + 2'h1;
				vld_r <= 1'b1;
			end
			2'b01: begin
				slot0_r <= slot1_r;
				cnt_r   <= cnt_r - 2'h1;
				vld_r   <= (cnt_r == 2'h2);
			end
			2'b11: begin
				// Head leaves; with one held the new word becomes head, with two it lands behind the survivor
				if (cnt_r == 2'h1)
					slot0_r <= in_data_i;
				else begin
					slot0_r <= slot1_r;
					slot1_r <= in_data_i;
				end
			end
			default: begin
				cnt_r <= cnt_r;
			end
			endcase
		end
	end

endmodule // two_entry_buffer

// File: test/link_partner.sv
/*
 * Link core model: grants arbitration and takes stream words.
 * Assumes it shares clk_i and srst_i with the formatter.
 */
`timescale 1ns/10ps

module link_partner (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Arbitration
	input  wire logic        arb_req_i,
	output logic             arb_grant_o,
	// Stream
	input  wire logic [31:0] tx_data_i,
	input  wire logic        tx_valid_i,
	input  wire logic        tx_first_i,
	input  wire logic        tx_last_i,
	input  wire logic        slow_i,
	output wire logic        tx_ready_o
);
	logic [33:0] got[$];     // Taken words with first and last flags
	logic [1:0]  ph_r;       // Stall phase
	logic        gnt_done_r; // Grant already given to this request

	// One grant per request; slow mode takes one word in four
	always @(posedge clk_i) begin
		if (srst_i) begin
			arb_grant_o <= 1'b0;
			gnt_done_r  <= 1'b0;
			ph_r        <= 2'h0;
		end else begin
			ph_r        <= ph_r + 2'h1;
			arb_grant_o <= arb_req_i && !gnt_done_r && !arb_grant_o;
			gnt_done_r  <= arb_req_i && (gnt_done_r || arb_grant_o);
			if (tx_valid_i && tx_ready_o) begin
				got.push_back({tx_first_i, tx_last_i, tx_data_i});
			end
		end
	end
	assign tx_ready_o = !srst_i && (!slow_i || ph_r == 2'h0);
endmodule // link_partner

// File: test/tb_async_tx_packet_formatter.sv
/*
 * Self-checking bench of the formatter: APB host, link model, receive headers.
 * Assumes default DEPTH of 24 quadlets.
 */
`timescale 1ns/10ps
`include "async_tx_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module tb_async_tx_packet_formatter;
	logic        clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0]  paddr_i = 0;
	logic [31:0] pwdata_i = 0;
	logic        ack_sent_i = 0, slow = 0, rx_hdr_valid_i = 0;
	logic [3:0]  rx_tcode_i = 0, rx_ack_i = 0;
	logic [1:0]  rx_spd_i = 0;
	wire  [31:0] prdata_o, tx_data_o, rx_status_o;
	wire  [1:0]  tx_spd_o, tx_rt_o, rx_class_o;
	wire         pready_o, pslverr_o, arb_req_o, arb_prio_o, arb_grant_i, tx_valid_o;
	wire         tx_first_o, tx_last_o, tx_ready_i, tx_crc_en_o, tx_no_arb_o, rx_done_o;
	int          miscompares = 0, n_tests = 0, cyc = 0;
	logic [31:0] rd;
	logic        er;

	always #12.5 clk_i = ~clk_i;

	async_tx_formatter DUT (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .arb_req_o, .arb_prio_o, .arb_grant_i,
		.ack_sent_i, .tx_data_o, .tx_valid_o, .tx_first_o, .tx_last_o, .tx_ready_i, .tx_spd_o,
		.tx_rt_o, .tx_crc_en_o, .tx_no_arb_o, .rx_hdr_valid_i, .rx_tcode_i, .rx_spd_i,
		.rx_ack_i, .rx_class_o, .rx_status_o, .rx_done_o);
	link_partner PT (.clk_i, .srst_i, .arb_req_i(arb_req_o), .arb_grant_o(arb_grant_i),
		.tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_first_i(tx_first_o),
		.tx_last_i(tx_last_o), .slow_i(slow), .tx_ready_o(tx_ready_i));

	// ************************************************
	// Shared tasks
	// ************************************************
	task print_verdict;
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	// One APB transfer; holds everything until pready is seen at an edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		k = 0;
		do begin @(posedge clk_i); k++; end while (pready_o !== 1'b1 && k < 50);
		if (pready_o !== 1'b1) miscompares++;
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 0; penable_i <= 0;
	endtask

	// Control quadlet: imm, speed, label, retry, code, priority
	function automatic logic [31:0] cq(logic i, logic [1:0] s, logic [5:0] l, logic [1:0] r,
		logic [3:0] t, logic [3:0] p);
		cq = {8'h0, i, 5'h0, s, l, r, t, p};
	endfunction

	// Loads a whole packet, starts it and checks the stream
	task automatic send_pkt(input logic [31:0] q[$], input logic imm);
		int n, k;
		logic req, prio, na, crc;
		n = q.size(); req = 0; prio = 0; na = 0; crc = 0; k = 0;
		PT.got.delete();
		foreach (q[i]) apb(1, `ADDR_TXDATA, q[i]);
		apb(1, `ADDR_CTRL, {19'h0, n[4:0], 7'h0, 1'b1});
		while (PT.got.size() < n && k < 400) begin
			@(posedge clk_i);
			k++;
			ack_sent_i <= imm && k == 12;
			if (arb_req_o) begin req = 1; prio = arb_prio_o; end
			if (tx_valid_o && tx_first_o) begin na = tx_no_arb_o; crc = tx_crc_en_o; end
		end
		`CHK(req, !imm)
		`CHK(na, imm)
		if (!imm) `CHK(prio, q[0][3:0] != 4'h0)
		`CHK(crc, q[0][7:4] != `TCODE_UNFMT)
		`CHK(PT.got.size(), n)
		foreach (PT.got[i]) `CHK(PT.got[i], {i == 0, i == n - 1, q[i]})
		k = 0;
		do begin apb(0, `ADDR_STATUS, 0); k++; end while (rd[0] !== 1'b0 && k < 50);
		`CHK(rd[0], 1'b0)
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	task t_reset;
		`CHK({tx_crc_en_o, rx_class_o, arb_req_o, tx_valid_o}, 5'h1c)
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[12:0], 13'h0)
		apb(0, 8'h10, 0);
		`CHK(er, 1'b1)
		$display("test reset done");
	endtask

	task t_block; // Block write with payload, slow receiver, priority set
		slow <= 1;
		send_pkt('{cq(0, 1, 5, 2, `TC_WR_BLK_REQ, 3), {10'h3ff, 6'h01, 16'h0}, 32'h0,
			{16'd4, 16'h0}, 32'h11223344}, 0);
		slow <= 0;
		send_pkt('{cq(0, 2, 9, 1, `TC_RD_BLK_REQ, 0), {10'h0, 6'h02, 16'h0}, 32'h0,
			{16'd16, 16'h0}}, 0);
		send_pkt('{cq(0, 0, 3, 0, `TC_WR_BLK_REQ, 0), {10'h0, 6'h03, 16'h0}, 32'h0,
			32'h0}, 0);
		$display("test block done");
	endtask

	task t_codes; // Speed codes 0 to 2 and every retry code, normal arbitration
		for (int i = 0; i < 4; i++)
			send_pkt('{cq(0, i % 3, i, i, `TC_RD_QUAD_REQ, 0)}, 0);
		$display("test codes done");
	endtask

	task t_imm; // Lock response sent straight after an acknowledge
		send_pkt('{cq(1, 0, 7, 0, `TC_LOCK_RESP, 0), {16'h0041, 16'h0}, 32'h0,
			{16'd8, 16'h0002}, 32'ha5a50001, 32'h5a5a0002}, 1);
		$display("test imm done");
	endtask

	task t_raw; // Configuration and link-on packets, host-made check quadlet
		logic [31:0] pc, lo;
		pc = {2'b00, 6'h05, 1'b1, 1'b1, 6'h3f, 16'h0};
		lo = {2'b01, 6'h2a, 24'h0};
		send_pkt('{cq(0, 0, 0, 0, `TCODE_UNFMT, 0), pc, ~pc}, 0);
		send_pkt('{cq(0, 0, 0, 0, `TCODE_UNFMT, 0), lo, ~lo}, 0);
		$display("test raw done");
	endtask

	task t_badspd; // Reserved speed is consumed, never sent, flagged
		PT.got.delete();
		apb(1, `ADDR_TXDATA, cq(0, 3, 0, 0, `TC_WR_QUAD_REQ, 0));
		apb(1, `ADDR_CTRL, 32'h101);
		repeat (30) @(posedge clk_i);
		`CHK(PT.got.size(), 0)
		apb(0, `ADDR_STATUS, 0);
		`CHK({rd[12:8], rd[1:0]}, 7'h02)
		apb(1, `ADDR_STATUS, 32'h2);
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[1], 1'b0)
		$display("test badspd done");
	endtask

	task t_fifo; // Fill to refusal, then flush
		for (int i = 0; i < 25; i++) begin
			apb(1, `ADDR_TXDATA, i);
			`CHK(er, i == 24)
		end
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[12:8], 5'd24)
		apb(1, `ADDR_CTRL, 32'h2);
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[12:8], 5'd0)
		$display("test fifo done");
	endtask

	task t_rx; // All nine transaction codes of the sorter plus code 8 sorted, status quadlet kept
		logic [3:0] tc[10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'h8};
		logic [1:0] cl[10] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rx_hdr_valid_i <= 1; rx_tcode_i <= tc[i]; rx_spd_i <= i % 3; rx_ack_i <= i + 1;
			@(posedge clk_i);
			rx_hdr_valid_i <= 0;
			#1;
			`CHK({rx_done_o, rx_class_o}, {1'b1, cl[i]})
			apb(0, `ADDR_RXSTAT, 0);
			`CHK({rd[17:16], rd[3:0]}, {2'(i % 3), 4'(i + 1)})
		end
		$display("test rx done");
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		srst_i <= 0;
		@(posedge clk_i);
		#1;
		t_reset();
		t_block();
		t_codes();
		t_imm();
		t_raw();
		t_badspd();
		t_fifo();
		t_rx();
		print_verdict();
	end
endmodule // tb_async_tx_packet_formatter

// File: test/tx_fmt_props.sv
/*
 * Checker for the transmit stream and receive sorter ports of the formatter.
 * Assumes one clock, clk_i, and a synchronous active-high srst_i.
 */
`timescale 1ns/10ps
`include "async_tx_defs.vh"

module tx_fmt_props (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	// Transmit stream
	input wire logic [31:0] tx_data_o,
	input wire logic        tx_valid_o,
	input wire logic        tx_first_o,
	input wire logic        tx_ready_i,
	input wire logic [1:0]  tx_spd_o,
	input wire logic [1:0]  tx_rt_o,
	input wire logic        tx_crc_en_o,
	// Receive sorter
	input wire logic        rx_hdr_valid_i,
	input wire logic [3:0]  rx_tcode_i,
	input wire logic [1:0]  rx_spd_i,
	input wire logic [3:0]  rx_ack_i,
	input wire logic [1:0]  rx_class_o,
	input wire logic [31:0] rx_status_o,
	input wire logic        rx_done_o
);
	// Storage format a received code must land in
	function automatic logic [1:0] cls_of(input logic [3:0] tc);
		case (tc)
			`TC_RD_QUAD_REQ, `TC_WR_RESP: cls_of = `CLS_NODATA;
			`TC_WR_QUAD_REQ, `TC_RD_QUAD_RESP, `TC_RD_BLK_REQ: cls_of = `CLS_QUADLET;
			`TC_LOCK_REQ, `TC_LOCK_RESP, `TC_WR_BLK_REQ, `TC_RD_BLK_RESP: cls_of = `CLS_BLOCK;
			default: cls_of = `CLS_NONE;
		endcase
	endfunction

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// ************************************************
	// Receive side
	// ************************************************
	property p_done; rx_hdr_valid_i |=> rx_done_o; endproperty
	a_done: assert property (p_done) else $error("done pulse missing");
	property p_cls; rx_hdr_valid_i |=> rx_class_o == cls_of($past(rx_tcode_i)); endproperty
	a_cls: assert property (p_cls) else $error("wrong receive format");
	property p_stat;
		rx_hdr_valid_i |=> rx_status_o[17:16] == $past(rx_spd_i) &&
			rx_status_o[3:0] == $past(rx_ack_i);
	endproperty
	a_stat: assert property (p_stat) else $error("status quadlet wrong");

	// ************************************************
	// Transmit side
	// ************************************************
	// Attributes must already match the control quadlet on its way out
	property p_spd;
		tx_valid_o && tx_first_o |-> tx_spd_o == tx_data_o[17:16] &&
			tx_data_o[17:16] != `SPD_RESERVED;
	endproperty
	a_spd: assert property (p_spd) else $error("speed mismatch");
	property p_rt; tx_valid_o && tx_first_o |-> tx_rt_o == tx_data_o[9:8]; endproperty
	a_rt: assert property (p_rt) else $error("retry code mismatch");
	property p_nocrc;
		tx_valid_o && tx_first_o && tx_data_o[7:4] == `TCODE_UNFMT |-> !tx_crc_en_o;
	endproperty
	a_nocrc: assert property (p_nocrc) else $error("crc on raw packet");
	property p_crc;
		tx_valid_o && tx_first_o && tx_data_o[7:4] != `TCODE_UNFMT |-> tx_crc_en_o;
	endproperty
	a_crc: assert property (p_crc) else $error("crc off on formatted packet");
	// A stalled word must stay put, or bytes get lost or reordered
	property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
	a_hold: assert property (p_hold) else $error("word changed under stall");
endmodule // tx_fmt_props

bind async_tx_formatter tx_fmt_props u_props (.clk_i, .srst_i, .tx_data_o, .tx_valid_o,
	.tx_first_o, .tx_ready_i, .tx_spd_o, .tx_rt_o, .tx_crc_en_o, .rx_hdr_valid_i, .rx_tcode_i,
	.rx_spd_i, .rx_ack_i, .rx_class_o, .rx_status_o, .rx_done_o);
